// ===== idle_timer_params.svh
// Register offsets, field positions, reset values and timing constants of the idle wakeup timer
`ifndef IDLE_TIMER_PARAMS_SVH
`define IDLE_TIMER_PARAMS_SVH

`define OFF_MODE          12'h000
`define OFF_ICTRL         12'h004
`define OFF_STATUS        12'h008
`define OFF_PORTG         12'h00c

`define SEL_LSB           0
`define SEL_MSB           2
`define RSVD_BIT          3
`define CORE_CLOCK_SELECT_BIT        4
`define DUAL_CLOCK_ENABLE_BIT          5
`define HIGH_SPEED_OSC_ON_BIT          6
`define LOW_SPEED_OSC_ON_BIT          7
`define PEND_BIT          5
`define IEN_BIT           4
`define GIE_BIT           0
`define WAKE_BIT          6

`define MODE_RESET        8'hc0
`define ICTRL_RESET       8'h00
`define PORTG_RESET       8'hff
`define PWR_BITS_ZERO     4'h0

`define CNT_WIDTH         16
`define CNT_RESET         16'hffff
`define TAP_BASE          11
`define SEL_MAX           3'h4

`define CLK_HZ            25000000
`define SLOW_HZ           32768
`define INST_DIV          5
`define SLOW_DIV          ((`CLK_HZ) / (`SLOW_HZ))

`endif

// ===== idle_timer_pkg.sv
// Types shared by the idle wakeup timer
package idle_timer_pkg;

    typedef struct packed {
        logic       low_speed_osc_on;
        logic       high_speed_osc_on;
        logic       dual_clock_enable;
        logic       core_clock_select;
        logic       rsvd;
        logic [2:0] period_select;
    } idle_timer_mode_t;

    typedef enum logic [1:0] {
        CLK_HIGH = 2'b00,
        CLK_DUAL = 2'b01,
        CLK_LOW  = 2'b11
    } clk_mode_t;

    typedef struct packed {
        logic wake_tick;
        logic watchdog_tick;
        logic startup_tick;
    } tick_bus_t;

endpackage

// ===== idle_wakeup_timer.sv
// Idle wakeup timer: down counter with tap select, pending flag, wake bit and APB registers
//
// How it works
// [R1] Sixteen-bit down counter, not writable; software reads only its selected tap bit in status.
// [R2] High speed mode counts instruction clock; dual or low speed counts 32 kHz.
// [R3] Instruction-cycle divider is stopped outside high speed mode.
// [R4] Selected tap among counter bits 11..15 sets pending flag on underflow.
// [R5] Period select is mode bits 2:0; codes 0..4 pick taps, 5..7 reserved.
// [R6] Every tap underflow clears port G data bit 6 to leave idle.
// [R7] Interrupt request needs pending, idle interrupt enable and global enable.
// [R8] Pending flag is control bit 5, interrupt enable is control bit 4.
// [R9] Reset clears period select, giving the 4096-cycle period.
// [R10] Software writes zero to mode bit 3, never uses it as a flag.
// [R11] Writing zero to all four power-mode bits requests a device reset.
// [R12] Software disables the interrupt and clears pending when changing period.
// [R13] Tap ticks also serve watchdog and halt or brownout start-up delays.
// [R14] Pending stays set until software clears it; software may also write it.
`timescale 1ns/1ps
`include "idle_timer_params.svh"

module idle_wakeup_timer (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic                              irq,
    output logic                              port_g_wake,
    output logic                              power_mode_reset_req,
    output idle_timer_pkg::tick_bus_t         ticks,
    output idle_timer_pkg::clk_mode_t         clk_mode
);
    import idle_timer_pkg::*;

    idle_timer_mode_t         mode;
    idle_timer_mode_t         next_mode;
    logic [7:0]               ictrl;
    logic [7:0]               next_ictrl;
    logic [7:0]               portg;
    logic [7:0]               next_portg;
    logic [`CNT_WIDTH-1:0]    cnt;
    logic [`CNT_WIDTH-1:0]    next_cnt;
    logic [2:0]               inst_div;
    logic [2:0]               next_inst_div;
    logic [9:0]               slow_div;
    logic [9:0]               next_slow_div;
    logic                     tap_prev;
    logic                     next_tap_prev;
    logic                     reset_req;
    logic                     next_reset_req;
    logic [31:0]              next_prdata;
    clk_mode_t                mode_now;
    logic                     cnt_en;
    logic                     tap_bit;
    logic                     underflow;
    logic                     wr_en;
    logic                     rd_en;
    logic                     addr_ok;

    // Decode power-save mode from the upper mode bits
    function automatic clk_mode_t decode_mode(input idle_timer_mode_t m);
        if (m.high_speed_osc_on && !m.core_clock_select) begin
            decode_mode = CLK_HIGH;
        end else if (m.high_speed_osc_on) begin
            decode_mode = CLK_DUAL;
        end else begin
            decode_mode = CLK_LOW;
        end
    endfunction

    // Pick the counter bit that feeds the interrupt, saturating reserved codes
    function automatic logic pick_tap(input logic [`CNT_WIDTH-1:0] c, input logic [2:0] s);
        logic [2:0] k;
        k = (s > `SEL_MAX) ? `SEL_MAX : s;
        pick_tap = c[`TAP_BASE + k];
    endfunction

    // Bus strobes; no wait states so the slave always answers in the access phase
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign addr_ok  = (paddr == `OFF_MODE) || (paddr == `OFF_ICTRL) ||
                      (paddr == `OFF_STATUS) || (paddr == `OFF_PORTG);
    assign pslverr  = psel && penable && !addr_ok;

    assign mode_now = decode_mode(mode);
    assign clk_mode = mode_now;

    // Count enable: divided instruction clock or 32 kHz tick
    always_comb begin
        next_inst_div = 3'h0;                                           // R3
        next_slow_div = slow_div;
        cnt_en        = 1'b0;
        if (mode_now == CLK_HIGH) begin
            if (inst_div == 3'(`INST_DIV - 1)) begin
                cnt_en = 1'b1;                                          // R2
            end else begin
                next_inst_div = inst_div + 3'h1;
            end
        end
        if (slow_div == 10'(`SLOW_DIV - 1)) begin
            next_slow_div = 10'h000;
            if (mode_now != CLK_HIGH) begin
                cnt_en = 1'b1;                                          // R2
            end
        end else begin
            next_slow_div = slow_div + 10'h001;
        end
    end

    // Down counter and tap edge detect; only the selected tap bit of the count is on the bus
    always_comb begin
        next_cnt      = cnt_en ? cnt - 16'h0001 : cnt;                  // R1
        tap_bit       = pick_tap(cnt, mode.period_select);              // R4 R5
        next_tap_prev = tap_bit;
        underflow     = tap_prev && !tap_bit;                           // R4
    end

    // Register state; underflow set beats a software clear of pending
    always_comb begin
        next_mode      = mode;
        next_ictrl     = ictrl;
        next_portg     = portg;
        next_reset_req = 1'b0;
        if (wr_en && pstrb[0]) begin
            case (paddr)
                `OFF_MODE: begin
                    next_mode = idle_timer_mode_t'(pwdata[7:0]);        // R5
                    if (pwdata[7:4] == `PWR_BITS_ZERO) begin
                        next_reset_req = 1'b1;                          // R11
                        next_mode      = mode;
                    end
                end
                `OFF_ICTRL: begin
                    next_ictrl = pwdata[7:0];                           // R14
                end
                `OFF_PORTG: begin
                    next_portg = pwdata[7:0];
                end
                default: begin
                    next_ictrl = ictrl;
                end
            endcase
        end
        if (underflow) begin
            next_ictrl[`PEND_BIT] = 1'b1;                               // R4 R14
            next_portg[`WAKE_BIT] = 1'b0;                               // R6
        end
    end

    // Read mux, captured in the setup phase so data is a flop in the access phase
    always_comb begin
        next_prdata = prdata;
        if (rd_en) begin
            case (paddr)
                `OFF_MODE:   next_prdata = {24'h000000, mode};
                `OFF_ICTRL:  next_prdata = {24'h000000, ictrl};
                `OFF_STATUS: next_prdata = {29'h0, tap_bit, clk_mode};
                `OFF_PORTG:  next_prdata = {24'h000000, portg};
                default:     next_prdata = 32'h00000000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode      <= idle_timer_mode_t'(`MODE_RESET);               // R9
            ictrl     <= `ICTRL_RESET;
            portg     <= `PORTG_RESET;
            cnt       <= `CNT_RESET;
            inst_div  <= 3'h0;
            slow_div  <= 10'h000;
            tap_prev  <= 1'b1;
            reset_req <= 1'b0;
            prdata    <= 32'h00000000;
        end else begin
            mode      <= next_mode;
            ictrl     <= next_ictrl;
            portg     <= next_portg;
            cnt       <= next_cnt;
            inst_div  <= next_inst_div;
            slow_div  <= next_slow_div;
            tap_prev  <= next_tap_prev;
            reset_req <= next_reset_req;
            prdata    <= next_prdata;
        end
    end

    // Outputs; tick fan-out shares one underflow for watchdog and start-up timing
    assign irq = ictrl[`PEND_BIT] && ictrl[`IEN_BIT] && ictrl[`GIE_BIT];  // R7 R8
    assign port_g_wake          = portg[`WAKE_BIT];
    assign power_mode_reset_req = reset_req;
    assign ticks.wake_tick      = underflow;
    assign ticks.watchdog_tick  = underflow;                            // R13
    assign ticks.startup_tick   = underflow;                            // R13

endmodule

// ===== idle_wakeup_timer_sva.sv
// Port assertions for the idle wakeup timer
`timescale 1ns/1ps
`include "idle_timer_params.svh"
module idle_wakeup_timer_sva (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [3:0]                pstrb,
    input wire logic                      pslverr,
    input wire logic                      irq,
    input wire logic                      port_g_wake,
    input wire logic                      power_mode_reset_req,
    input wire idle_timer_pkg::tick_bus_t ticks
);
    import idle_timer_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access decode used by several properties
    wire acc = psel && penable;
    wire zero_wr = acc && pwrite && pstrb[0] && paddr == `OFF_MODE && pwdata[7:4] == 4'h0;
    wire mapped = paddr inside {`OFF_MODE, `OFF_ICTRL, `OFF_STATUS, `OFF_PORTG};

    a_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_pwr_zero_req: assert property (zero_wr |=> power_mode_reset_req)
        else $error("no reset request");
    a_req_has_cause: assert property (power_mode_reset_req |-> $past(zero_wr))
        else $error("reset request without cause");
    a_req_one_cycle: assert property (power_mode_reset_req |=> !power_mode_reset_req)
        else $error("reset request too long");
    a_tick_wake_low: assert property (ticks.wake_tick |=> !port_g_wake)
        else $error("wake bit not cleared");
    a_ticks_shared: assert property (ticks.watchdog_tick == ticks.wake_tick
        && ticks.startup_tick == ticks.wake_tick)
        else $error("tick outputs differ");
    a_tick_spacing: assert property (ticks.wake_tick |=> !ticks.wake_tick [*8])
        else $error("ticks too close");
    a_wake_fall_cause: assert property ($fell(port_g_wake) |-> $past(ticks.wake_tick)
        || $past(acc && pwrite && paddr == `OFF_PORTG))
        else $error("wake bit fell without cause");
    // Main scenarios reached
    c_tick: cover property (ticks.wake_tick);
    c_req: cover property (power_mode_reset_req);
    c_irq: cover property ($rose(irq));
endmodule

bind idle_wakeup_timer idle_wakeup_timer_sva chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pslverr, .irq, .port_g_wake, .power_mode_reset_req, .ticks);

// ===== tb_idle_wakeup_timer.sv
// Self-checking testbench of the idle wakeup timer
`timescale 1ns/1ps
`include "idle_timer_params.svh"
module tb_idle_wakeup_timer;
    import idle_timer_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, irq, err;
    logic        port_g_wake, power_mode_reset_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    tick_bus_t   ticks;
    clk_mode_t   clk_mode;
    int          bad_count, cmp_count, n;
    logic [7:0]  iv [4] = '{8'h31, 8'h30, 8'h21, 8'h01};
    logic [7:0]  mv [3] = '{8'hd0, 8'h80, 8'hc0};
    clk_mode_t   cm [3] = '{CLK_DUAL, CLK_LOW, CLK_HIGH};

    idle_wakeup_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .irq, .port_g_wake, .power_mode_reset_req, .ticks, .clk_mode);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Cycles until the next wake tick, bounded so a dead tap cannot hang
    task automatic wait_tick();
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (ticks.wake_tick !== 1'b1 && n < 60000);
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog sized a little above the two long period measurements
    initial begin
        #(125000 * 40);
        bad_count++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, `OFF_MODE, 0);
        chk("mode reset", 32'hc0, rd);
        xfer(1'b0, 12'h010, 0);
        chk("hidden counter", 0, rd);
        chk("unmapped error", 1, err);
        wait_tick();
        wait_tick();
        chk("tap 11 period", 4096 * `INST_DIV, n);
        repeat (2) @(negedge pclk);
        chk("wake bit", 0, port_g_wake);
        xfer(1'b0, `OFF_ICTRL, 0);
        chk("pending set", 32'h20, rd);
        // Interrupt needs pending, enable and global enable together
        foreach (iv[i]) begin
            xfer(1'b1, `OFF_ICTRL, {24'h0, iv[i]});
            @(negedge pclk);
            chk("irq", {31'h0, iv[i] == 8'h31}, {31'h0, irq});
        end
        xfer(1'b0, `OFF_ICTRL, 0);
        chk("pending cleared", 32'h01, rd);
        xfer(1'b1, `OFF_MODE, 0);
        @(negedge pclk);
        chk("reset request", 1, power_mode_reset_req);
        xfer(1'b0, `OFF_MODE, 0);
        chk("zero write refused", 32'hc0, rd);
        foreach (mv[i]) begin
            xfer(1'b1, `OFF_MODE, {24'h0, mv[i]});
            @(negedge pclk);
            chk("clock mode", cm[i], clk_mode);
        end
        // Period change may fire a false tick one cycle after the write; let it pass
        xfer(1'b1, `OFF_ICTRL, 32'h00);
        xfer(1'b1, `OFF_MODE, 32'hc1);
        repeat (2) @(posedge pclk);
        xfer(1'b1, `OFF_ICTRL, 32'h00);
        wait_tick();
        wait_tick();
        chk("tap 12 period", 8192 * `INST_DIV, n);
        results();
    end
endmodule
